// ### core/sjt_tap.sv
`timescale 1ns/10ps
module sjt_fifo
#(
    parameter int W = 8,
    parameter int D = 2
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(D - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(D);
    logic [W-1:0] mem [D];
    logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [CW-1:0] cnt, next_cnt;
    logic push, pop;

    assign in_ready = (cnt != CNT_FULL);
    assign out_valid = (cnt != '0);
    assign out_data = mem[rd_ptr];
    assign push = en && in_valid && in_ready;
    assign pop = en && out_valid && out_ready;

    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_cnt = cnt;
        if (push)
        begin
            next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'h1;
        end
        if (pop)
        begin
            next_rd_ptr = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'h1;
        end
        if (push && !pop)
        begin
            next_cnt = cnt + 1'h1;
        end
        else if (pop && !push)
        begin
            next_cnt = cnt - 1'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            cnt <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

module sjt_tap
    import sjt_pkg::*;
#(
    // Identity values are arbitrary
    parameter logic [2:0] ID_REV = 3'h0,
    parameter logic [4:0] ID_DEPTH = 5'h01,
    parameter logic [5:0] ID_ARCH = 6'h2A,
    parameter logic [5:0] ID_DENS = 6'h15,
    parameter logic [10:0] ID_VENDOR = 11'h155
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire sjt_ring_t ring_in,
    output logic tdo,
    output logic tdo_oe_n,
    output logic mem_out_hiz
);
    // System clock side: ring sampling and float control
    sjt_ring_t ring_s1, ring_s2, samp;
    logic samp_vld, fifo_in_ready, fifo_out_valid;
    sjt_ring_t fifo_out_data;
    sjt_xfer_t xfer, next_xfer;
    logic ack_s1, ack_s2, hiz_s1, hiz_s2, next_hiz;
    logic hs_idle, hiz_req, ack_tgl;

    sjt_fifo #(.W(BSR_LEN), .D(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .en(ce),
        .in_valid(samp_vld),
        .in_ready(fifo_in_ready),
        .in_data(samp),
        .out_valid(fifo_out_valid),
        .out_ready(hs_idle),
        .out_data(fifo_out_data)
    );

    assign hs_idle = (xfer.req == ack_s2);

    always_comb
    begin
        next_xfer = xfer;
        if (hs_idle && fifo_out_valid)
        begin
            next_xfer.data = fifo_out_data;
            next_xfer.req = !xfer.req;
        end
        next_hiz = hiz_s2;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ring_s1 <= '0;
            ring_s2 <= '0;
            samp <= '0;
            samp_vld <= 1'h0;
            xfer <= '0;
            ack_s1 <= 1'h0;
            ack_s2 <= 1'h0;
            hiz_s1 <= 1'h0;
            hiz_s2 <= 1'h0;
            mem_out_hiz <= 1'h0;
        end
        else if (ce)
        begin
            ring_s1 <= ring_in;
            ring_s2 <= ring_s1;
            if (fifo_in_ready)
            begin
                samp <= ring_s2;
                samp_vld <= 1'h1;
            end
            xfer <= next_xfer;
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
            hiz_s1 <= hiz_req;
            hiz_s2 <= hiz_s1;
            mem_out_hiz <= next_hiz;
        end
    end

    // Test clock side
    logic [1:0] trst_q;
    logic tck_rst_n;
    sjt_state_t state, next_state;
    logic [IR_LEN-1:0] ir, ir_shift, next_ir, next_ir_shift;
    sjt_ring_t dr_shift, next_dr_shift, ring_shadow, next_shadow;
    logic byp, next_byp, next_hiz_req;
    logic req_s1, req_s2, next_ack;
    logic sel_id, sel_bsr, next_tdo, next_oe_n;
    sjt_id_t id_val;

    assign tck_rst_n = trst_q[1];
    assign id_val = '{rev: ID_REV,
                      depth: {ID_DEPTH[4:1], DEPTH_MARK},
                      arch: ID_ARCH,
                      dens: ID_DENS,
                      vendor: ID_VENDOR,
                      present: ID_PRESENT};
    assign sel_id = (ir == INS_IDCODE);
    assign sel_bsr = (ir == INS_EXTEST) || (ir == INS_SAMPZ)
                     || (ir == INS_SAMPLE);

    always_ff @(posedge tck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            trst_q <= 2'h0;
        end
        else
        begin
            trst_q <= {trst_q[0], 1'h1};
        end
    end

    always_comb
    begin
        case (state)
            TLR: next_state = tms ? TLR : RTI;
            RTI: next_state = tms ? SEL_DR : RTI;
            SEL_DR: next_state = tms ? SEL_IR : CAP_DR;
            CAP_DR: next_state = tms ? EX1_DR : SH_DR;
            SH_DR: next_state = tms ? EX1_DR : SH_DR;
            EX1_DR: next_state = tms ? UPD_DR : PA_DR;
            PA_DR: next_state = tms ? EX2_DR : PA_DR;
            EX2_DR: next_state = tms ? UPD_DR : SH_DR;
            UPD_DR: next_state = tms ? SEL_DR : RTI;
            SEL_IR: next_state = tms ? TLR : CAP_IR;
            CAP_IR: next_state = tms ? EX1_IR : SH_IR;
            SH_IR: next_state = tms ? EX1_IR : SH_IR;
            EX1_IR: next_state = tms ? UPD_IR : PA_IR;
            PA_IR: next_state = tms ? EX2_IR : PA_IR;
            EX2_IR: next_state = tms ? UPD_IR : SH_IR;
            UPD_IR: next_state = tms ? SEL_DR : RTI;
            default: next_state = TLR;
        endcase
    end

    always_comb
    begin
        next_ir = ir;
        next_ir_shift = ir_shift;
        next_dr_shift = dr_shift;
        next_byp = byp;
        next_shadow = ring_shadow;
        next_ack = ack_tgl;
        if (req_s2 != ack_tgl)
        begin
            next_shadow = xfer.data;
            next_ack = req_s2;
        end
        case (state)
            TLR: next_ir = INS_IDCODE;
            CAP_IR: next_ir_shift = IR_CAP_VAL;
            SH_IR: next_ir_shift = {tdi, ir_shift[IR_LEN-1:1]};
            UPD_IR: next_ir = ir_shift;
            CAP_DR:
            begin
                if (sel_bsr)
                begin
                    next_dr_shift = ring_shadow;
                end
                else if (sel_id)
                begin
                    next_dr_shift = '0;
                    next_dr_shift[ID_LEN-1:0] = id_val;
                end
                else
                begin
                    next_byp = BYP_CAP;
                end
            end
            SH_DR:
            begin
                if (sel_bsr)
                begin
                    next_dr_shift = {tdi, dr_shift[BSR_LEN-1:1]};
                end
                else if (sel_id)
                begin
                    next_dr_shift[ID_LEN-1:0] =
                        {tdi, dr_shift[ID_LEN-1:1]};
                end
                else
                begin
                    next_byp = tdi;
                end
            end
            default: next_ir = ir;
        endcase
        // Entering reset loads the default code on the same edge
        if (next_state == TLR)
        begin
            next_ir = INS_IDCODE;
        end
        next_hiz_req = (next_ir == INS_EXTEST)
                       || (next_ir == INS_SAMPZ);
    end

    always_ff @(posedge tck or negedge tck_rst_n)
    begin
        if (!tck_rst_n)
        begin
            state <= TLR;
            ir <= INS_IDCODE;
            ir_shift <= IR_CAP_VAL;
            dr_shift <= '0;
            byp <= BYP_CAP;
            hiz_req <= 1'h0;
            req_s1 <= 1'h0;
            req_s2 <= 1'h0;
            ack_tgl <= 1'h0;
            ring_shadow <= '0;
        end
        else
        begin
            state <= next_state;
            ir <= next_ir;
            ir_shift <= next_ir_shift;
            dr_shift <= next_dr_shift;
            byp <= next_byp;
            hiz_req <= next_hiz_req;
            req_s1 <= xfer.req;
            req_s2 <= req_s1;
            ack_tgl <= next_ack;
            ring_shadow <= next_shadow;
        end
    end

    always_comb
    begin
        next_oe_n = !((state == SH_IR) || (state == SH_DR));
        if (state == SH_IR)
        begin
            next_tdo = ir_shift[0];
        end
        else if (sel_bsr || sel_id)
        begin
            next_tdo = dr_shift[0];
        end
        else
        begin
            next_tdo = byp;
        end
    end

    // Serial output moves on the falling edge
    always_ff @(negedge tck or negedge tck_rst_n)
    begin
        if (!tck_rst_n)
        begin
            tdo <= 1'h0;
            tdo_oe_n <= 1'h1;
        end
        else
        begin
            tdo <= next_tdo;
            tdo_oe_n <= next_oe_n;
        end
    end

    a_tms_five_reset: assert property (
        @(posedge tck) disable iff (!tck_rst_n)
        tms [*5] |=> (state == TLR) && (ir == INS_IDCODE))
        else $error("five tms highs did not reset");

    a_fsm_rti_step: assert property (
        @(posedge tck) disable iff (!tck_rst_n)
        (state == RTI) && tms |=> (state == SEL_DR))
        else $error("run-idle step wrong");

    a_fsm_ir_pause: assert property (
        @(posedge tck) disable iff (!tck_rst_n)
        (state == EX1_IR) && !tms ##1 !tms |=> (state == PA_IR))
        else $error("ir pause path wrong");

    a_ir_capture_pat: assert property (
        @(posedge tck) disable iff (!tck_rst_n)
        (state == CAP_IR) |=> (ir_shift[1:0] == IR_CAP_VAL[1:0]))
        else $error("ir capture pattern wrong");

    a_id_capture_val: assert property (
        @(posedge tck) disable iff (!tck_rst_n)
        (state == CAP_DR) && (ir == INS_IDCODE)
        |=> (dr_shift[0] == ID_PRESENT) && (dr_shift[24] == DEPTH_MARK))
        else $error("id capture value wrong");

    a_bsr_capture_ring: assert property (
        @(posedge tck) disable iff (!tck_rst_n)
        (state == CAP_DR) && (ir == INS_SAMPLE)
        |=> (dr_shift == $past(ring_shadow)))
        else $error("ring not captured");

    a_bypass_cap_zero: assert property (
        @(posedge tck) disable iff (!tck_rst_n)
        (state == CAP_DR) && (ir == INS_BYPASS) |=> (byp == BYP_CAP))
        else $error("bypass capture not low");

    a_hiz_float_req: assert property (
        @(posedge tck) disable iff (!tck_rst_n)
        (state == UPD_IR) && (ir_shift == INS_SAMPZ)
        |=> hiz_req ##1 hiz_req)
        else $error("float request missing");

    a_tdo_idle_float: assert property (
        @(posedge tck) disable iff (!tck_rst_n)
        (state == RTI) |=> tdo_oe_n)
        else $error("tdo driven outside shift");

    a_hiz_memory_out: assert property (
        @(posedge clk) disable iff (!arst_n)
        ce && hiz_s2 ##1 ce |-> mem_out_hiz)
        else $error("memory outputs not floated");
endmodule

// ### core/sjt_pkg.sv
// Function
// - TAP steps on tck rise per tms
// - Chains: IR 3, bypass 1, ID 32, boundary 73
// - Code 000 captures ring, no preload drive
// - Code 001 selects ID, memory unaffected
// - Code 010 captures ring, outputs forced float
// - Code 100 captures ring, memory unaffected
// - Code 111 selects one-bit bypass
// - ID bit 0 is always one
// - ID revision 31:29, depth 28:24
// - ID type 23:18, density 17:12, vendor 11:1
// - ID bit 24 is always one
// - tdo changes on falling edge, shows LSB
// - Five tms-high edges reset, load ID code
// - Capture-IR loads low bits with 01
// - Code 000 acts as 100 plus float
package sjt_pkg;
    localparam int IR_LEN = 3;
    localparam int ID_LEN = 32;
    localparam int BSR_LEN = 73;
    localparam int FIFO_DEPTH = 2;
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDCODE = 3'h1;
    localparam logic [2:0] INS_SAMPZ = 3'h2;
    localparam logic [2:0] INS_SAMPLE = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;
    localparam logic [2:0] IR_CAP_VAL = 3'h1;
    localparam logic BYP_CAP = 1'h0;
    localparam logic ID_PRESENT = 1'h1;
    localparam logic DEPTH_MARK = 1'h1;
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } sjt_state_t;
    typedef struct packed {
        logic [2:0] rev;
        logic [4:0] depth;
        logic [5:0] arch;
        logic [5:0] dens;
        logic [10:0] vendor;
        logic present;
    } sjt_id_t;
    typedef logic [BSR_LEN-1:0] sjt_ring_t;
    typedef struct packed {
        logic req;
        sjt_ring_t data;
    } sjt_xfer_t;
endpackage

// ### testbench/sjt_ctl.sv
`timescale 1ns/10ps
module sjt_ctl
(
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe_n
);
    logic prev = 1'h0;

    initial
    begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
    end

    // Test clock pulses only inside a step, idle low otherwise
    task automatic step(input logic m, input logic d, output logic q);
    begin
        tms = m;
        tdi = d;
        #6 tck = 1'h1;
        // Released line shows the inverse of its last value
        q = tdo_oe_n ? ~prev : tdo;
        prev = q;
        #6 tck = 1'h0;
    end
    endtask

    task automatic tms_reset();
        logic q;
    begin
        repeat (5) step(1'h1, 1'h0, q);
        step(1'h0, 1'h0, q);
    end
    endtask

    // From idle through capture, shift, exit, update back to idle
    task automatic scan(input logic ir, input int n, input logic [72:0] din,
                        output logic [72:0] dout);
        logic q;
    begin
        dout = '0;
        step(1'h1, 1'h0, q);
        if (ir)
            step(1'h1, 1'h0, q);
        step(1'h0, 1'h0, q);
        step(1'h0, 1'h0, q);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        // Park in pause, then exit through update
        step(1'h0, 1'h0, q);
        step(1'h0, 1'h0, q);
        step(1'h1, 1'h0, q);
        step(1'h1, 1'h0, q);
        step(1'h0, 1'h0, q);
    end
    endtask
endmodule

// ### testbench/tb_sjt_tap.sv
`timescale 1ns/10ps
module tb_sjt_tap
    import sjt_pkg::*;
;
    // Identity values are arbitrary
    localparam logic [2:0] REV = 3'h5;
    localparam logic [4:0] DEPTH = 5'h12;
    localparam logic [5:0] ARCH = 6'h2A;
    localparam logic [5:0] DENS = 6'h15;
    localparam logic [10:0] VEND = 11'h155;
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic ce = 1'h1;
    sjt_ring_t ring_in = '0;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe_n;
    logic mem_out_hiz;
    int n_errors = 0;
    int checks_done = 0;
    string name_q[$];
    logic [72:0] exp_q[$];
    logic [72:0] res;
    logic [72:0] e;
    string s;
    event ev;

    always #4 clk = ~clk;

    always @(negedge clk)
        ce <= ($urandom % 4) != 0;

    sjt_tap #(.ID_REV(REV), .ID_DEPTH(DEPTH), .ID_ARCH(ARCH),
              .ID_DENS(DENS), .ID_VENDOR(VEND)) u_sjt_tap
    (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .ring_in(ring_in),
        .tdo(tdo),
        .tdo_oe_n(tdo_oe_n),
        .mem_out_hiz(mem_out_hiz)
    );

    sjt_ctl u_sjt_ctl
    (
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .tdo(tdo),
        .tdo_oe_n(tdo_oe_n)
    );

    task automatic note(input string n, input logic [72:0] v);
    begin
        name_q.push_back(n);
        exp_q.push_back(v);
    end
    endtask

    task automatic got(input logic [72:0] v);
    begin
        res = v;
        -> ev;
        #1;
    end
    endtask

    task automatic wrap_up();
    begin
        if (exp_q.size() != 0)
            n_errors++;
        if (n_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask

    // Oldest expectation against each result
    initial
    forever
    begin
        @(ev);
        checks_done++;
        if (exp_q.size() == 0)
        begin
            n_errors++;
            $display("unexpected result expected none seen %h", res);
        end
        else
        begin
            s = name_q.pop_front();
            e = exp_q.pop_front();
            if (res !== e)
            begin
                n_errors++;
                $display("unexpected %s expected %h seen %h", s, e, res);
            end
        end
    end

    task automatic chk_hiz(input logic x);
        int k;
    begin
        k = 0;
        while (mem_out_hiz !== x && k < 60)
        begin
            @(negedge clk);
            k++;
        end
        note("mem_out_hiz", 73'(x));
        got(73'(mem_out_hiz));
    end
    endtask

    initial
    begin
        #100000;
        n_errors++;
        wrap_up();
    end

    initial
    begin
        // Only defined codes are loaded
        logic [2:0] codes[5] = '{3'h0, 3'h2, 3'h4, 3'h1, 3'h7};
        logic [72:0] w;
        logic [72:0] din;
        logic [72:0] id;
        logic q;
        int n;
        void'($urandom(32'h6A239B7A));
        id = 73'({REV, DEPTH | 5'h01, ARCH, DENS, VEND, ID_PRESENT});
        repeat (8) @(negedge clk);
        arst_n = 1'h1;
        u_sjt_ctl.tms_reset();
        foreach (codes[i])
        begin
            @(negedge clk);
            ring_in = 73'({$urandom, $urandom, $urandom});
            din = 73'($urandom);
            // Idle test clocks let the ring sample reach the shadow
            repeat (60) u_sjt_ctl.step(1'h0, 1'h0, q);
            note("ir_capture", 73'(IR_CAP_VAL));
            u_sjt_ctl.scan(1'h1, IR_LEN, 73'(codes[i]), w);
            got(w);
            chk_hiz(codes[i] == INS_EXTEST || codes[i] == INS_SAMPZ);
            n = BSR_LEN;
            if (codes[i] == INS_BYPASS)
                n = 8;
            if (codes[i] == INS_IDCODE)
                n = ID_LEN;
            if (codes[i] == INS_BYPASS)
                note("bypass", 73'({din[6:0], BYP_CAP}));
            else if (codes[i] == INS_IDCODE)
                note("idcode", id);
            else
                note("ring", ring_in);
            u_sjt_ctl.scan(1'h0, n, din, w);
            got(w);
        end
        u_sjt_ctl.tms_reset();
        note("idcode", id);
        u_sjt_ctl.scan(1'h0, ID_LEN, din, w);
        got(w);
        wrap_up();
    end
endmodule
